// *** common/rx_status_map.vh ***
`ifndef RX_STATUS_MAP_VH
`define RX_STATUS_MAP_VH

// register byte offsets
`define OFS_RX_FRAME_STATUS  4'h0
`define OFS_RX_CTRL          4'h4
`define OFS_IRQ_STATUS       4'h8
`define OFS_IRQ_MASK         4'hc

// status word bit positions
`define BIT_OVERRUN_DROP     31
`define BIT_FILTER_PASS      30
`define BIT_ADDR_MATCH_FAIL  29
`define BIT_BCAST_DEST       28
`define BIT_GROUP_DEST       27

// control register bit positions
`define CTL_ACCEPT_ALL       0
`define CTL_BCAST_BLOCK      1
`define CTL_CTRL_PASS        2
`define CTL_BAD_PASS         3
`define CTL_FULL_DUPLEX      4
`define CTL_RX_ENABLE        5
`define CTL_WIDTH            6

// interrupt status / mask bit positions
`define IRQ_DONE             0
`define IRQ_OVERRUN          1
`define IRQ_FILTER_FAIL      2
`define IRQ_WIDTH            3

// reset values
`define CTL_RESET            6'h00
`define MASK_RESET           3'h0

// frame size limits in bytes
`define MAX_LEN_UNTAGGED     16'h05dc
`define MAX_LEN_ONE_TAG      16'h05ee
`define MAX_LEN_TWO_TAG      16'h0602
`define CTRL_FRAME_LEN       16'h0040

`endif

// *** logic/frame_filter_eval.v ***
`timescale 1ns/10ps
`include "rx_status_map.vh"

// combinational filter verdict for one completed frame
module frame_filter_eval (
    // frame attributes
    input  wire        addr_match_fail,
    input  wire        dest_bcast,
    input  wire        is_ctrl_frame,
    input  wire        ctrl_op_ok,
    input  wire        frame_err,
    input  wire [15:0] frame_len,
    input  wire [1:0]  vlan_tags,
    input  wire        full_duplex,
    // software settings
    input  wire        accept_all_addr_mode,
    input  wire        bcast_block_ctl,
    input  wire        ctrl_frame_pass,
    input  wire        bad_frame_pass,
    // results
    output wire        unknown_ctrl_frame,
    output wire        filter_pass
);
    reg  [15:0] max_len;
    wire        oversize;
    wire        err_status;
    wire        fail_a;
    wire        fail_b;
    wire        fail_c;
    wire        fail_d;
    wire        fail_e;

    // length limit chosen by tag count
    always @* begin
        case (vlan_tags)
            2'h0:    max_len = `MAX_LEN_UNTAGGED;
            2'h1:    max_len = `MAX_LEN_ONE_TAG;
            default: max_len = `MAX_LEN_TWO_TAG;
        endcase
    end

    assign oversize   = frame_len > max_len;
    assign err_status = frame_err | oversize;

    // full duplex only; bad opcode or wrong length
    assign unknown_ctrl_frame = full_duplex & is_ctrl_frame &
        (~ctrl_op_ok | (frame_len != `CTRL_FRAME_LEN));

    // conditions kept exactly as worded, odd though they read
    assign fail_a = ~addr_match_fail &
                    (~dest_bcast | accept_all_addr_mode);
    assign fail_b = dest_bcast & ~bcast_block_ctl;
    assign fail_c = ~is_ctrl_frame | ctrl_frame_pass;
    assign fail_d = ~err_status | bad_frame_pass;
    assign fail_e = ~unknown_ctrl_frame;

    assign filter_pass = ~(fail_a | fail_b | fail_c | fail_d | fail_e);
endmodule // frame_filter_eval

// *** logic/dest_addr_class.v ***
`timescale 1ns/10ps

// classify destination address
module dest_addr_class #(
    parameter ADDR_W = 48
) (
    // address as received, first bit on the wire in bit 0
    input  wire [ADDR_W-1:0] dest_addr,
    // flags
    output wire              bcast_dest_flag,
    output wire              group_dest_flag
);
    assign bcast_dest_flag = &dest_addr;
    assign group_dest_flag = dest_addr[0];
endmodule // dest_addr_class

// *** logic/mac_rx_frame_status_word.v ***
// Function
// - status is valid only after the buffer is enabled and marked done.
// - bit 31 is one for a frame lost to a FIFO overrun, else zero.
// - bit 30 is one when the frame passed the packet filter, else zero.
// - fail if match-fail is 0 and (not broadcast or accept-all is 1).
// - filter fails when broadcast and broadcast-block is 0.
// - filter fails when not a control frame or control-pass is 1.
// - filter fails when no error status or bad-frame-pass is 1.
// - filter fails when the unknown-control indication is 0.
// - oversize frames (1500/1518/1538) give error status.
// - bit 29 is one when the destination failed address filtering.
// - bit 28 is one when the destination is all ones.
// - bit 27 is one when the destination's first bit is one.
// - full-duplex control frame, bad opcode or size not 64, is unknown.
// - blocked broadcasts and non-promiscuous address fails are dropped, except overrun frames, which are still stored.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "rx_status_map.vh"

module mac_rx_frame_status_word #(
    parameter ADDR_W = 48
) (
    // clock and reset
    input  wire              mclk,
    input  wire              rst,
    // avalon-mm slave
    input  wire [3:0]        avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    input  wire [3:0]        avs_byteenable,
    output reg  [31:0]       avs_readdata,
    output wire              avs_waitrequest,
    output reg  [1:0]        avs_response,
    // receive datapath, one-cycle completion strobe
    input  wire              frm_done,
    input  wire              frm_overrun,
    input  wire [ADDR_W-1:0] frm_dest_addr,
    input  wire              frm_addr_fail,
    input  wire              frm_is_ctrl,
    input  wire              frm_ctrl_op_ok,
    input  wire              frm_error,
    input  wire [15:0]       frm_len,
    input  wire [1:0]        frm_vlan_tags,
    // promiscuous mode level from mac control
    input  wire              promisc_mode,
    // outputs
    output wire              buf_done,
    output wire              frame_stored,
    output wire              irq
);
    reg  [31:0]             status_r;
    reg                     done_r;
    reg  [`CTL_WIDTH-1:0]   ctl_r;
    reg  [`IRQ_WIDTH-1:0]   irq_stat_r;
    reg  [`IRQ_WIDTH-1:0]   irq_mask_r;
    reg  [`IRQ_WIDTH-1:0]   irq_stat_nxt;
    reg                     ack_r;
    reg  [31:0]             rd_nxt;
    reg                     rd_err_nxt;
    wire                    bcast_dest_flag;
    wire                    group_dest_flag;
    wire                    unknown_ctrl_frame;
    wire                    filter_pass;
    wire                    keep_frame;
    wire                    commit;
    wire                    access;
    wire [31:0]             wmask;
    wire [`IRQ_WIDTH-1:0]   irq_evt;
    wire [`IRQ_WIDTH-1:0]   irq_clr;
    wire                    rx_en;

    dest_addr_class #(
        .ADDR_W (ADDR_W)
    ) u_class (
        .dest_addr       (frm_dest_addr),
        .bcast_dest_flag (bcast_dest_flag),
        .group_dest_flag (group_dest_flag)
    );

    frame_filter_eval u_filter (
        .addr_match_fail      (frm_addr_fail),
        .dest_bcast           (bcast_dest_flag),
        .is_ctrl_frame        (frm_is_ctrl),
        .ctrl_op_ok           (frm_ctrl_op_ok),
        .frame_err            (frm_error),
        .frame_len            (frm_len),
        .vlan_tags            (frm_vlan_tags),
        .full_duplex          (ctl_r[`CTL_FULL_DUPLEX]),
        .accept_all_addr_mode (ctl_r[`CTL_ACCEPT_ALL]),
        .bcast_block_ctl      (ctl_r[`CTL_BCAST_BLOCK]),
        .ctrl_frame_pass      (ctl_r[`CTL_CTRL_PASS]),
        .bad_frame_pass       (ctl_r[`CTL_BAD_PASS]),
        .unknown_ctrl_frame   (unknown_ctrl_frame),
        .filter_pass          (filter_pass)
    );

    assign rx_en = ctl_r[`CTL_RX_ENABLE];

    // broadcast block cuts broadcasts even in promiscuous mode;
    // an address-filter miss drops the frame only outside it
    assign keep_frame = ~(bcast_dest_flag & ctl_r[`CTL_BCAST_BLOCK]) &
                        (promisc_mode | ~frm_addr_fail);

    // an overrun frame is still reported so software can see it
    assign commit = frm_done & rx_en & ~done_r &
                    (keep_frame | frm_overrun);
    assign frame_stored = commit;

    // status and done flag load in the same cycle
    always @(posedge mclk) begin
        if (rst) begin
            status_r <= 32'h0000_0000;
            done_r   <= 1'b0;
        end else begin
            if (commit) begin
                status_r <= 32'h0000_0000;
                status_r[`BIT_OVERRUN_DROP]    <= frm_overrun;
                status_r[`BIT_FILTER_PASS]     <= filter_pass;
                status_r[`BIT_ADDR_MATCH_FAIL] <= frm_addr_fail;
                status_r[`BIT_BCAST_DEST]      <= bcast_dest_flag;
                status_r[`BIT_GROUP_DEST]      <= group_dest_flag;
                done_r <= 1'b1;
            end else if (avs_write & ack_r &
                         avs_address == `OFS_RX_CTRL &
                         avs_byteenable[0] &
                         ~avs_writedata[`CTL_RX_ENABLE]) begin
                done_r <= 1'b0; // disabling rearms the buffer
            end
        end
    end
    assign buf_done = done_r;

    // single wait state: the first cycle waits, the second answers
    assign access          = (avs_read | avs_write) & ~ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always @(posedge mclk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // read mux; status reads zero until the buffer completes
    always @* begin
        rd_nxt     = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        case (avs_address)
            `OFS_RX_FRAME_STATUS: rd_nxt = done_r ? status_r :
                                           32'h0000_0000;
            `OFS_RX_CTRL:    rd_nxt[`CTL_WIDTH-1:0] = ctl_r;
            `OFS_IRQ_STATUS: rd_nxt[`IRQ_WIDTH-1:0] = irq_stat_r;
            `OFS_IRQ_MASK:   rd_nxt[`IRQ_WIDTH-1:0] = irq_mask_r;
            default:         rd_err_nxt = 1'b1;
        endcase
    end

    // read data registered during the wait cycle
    always @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (access) begin
            avs_readdata <= avs_read ? rd_nxt : 32'h0000_0000;
            avs_response <= rd_err_nxt ? 2'h3 : 2'h0;
        end
    end

    // control and mask writes; status word is read-only
    always @(posedge mclk) begin
        if (rst) begin
            ctl_r      <= `CTL_RESET;
            irq_mask_r <= `MASK_RESET;
        end else if (avs_write & ack_r) begin
            if (avs_address == `OFS_RX_CTRL)
                ctl_r <= (ctl_r & ~wmask[`CTL_WIDTH-1:0]) |
                         (avs_writedata[`CTL_WIDTH-1:0] &
                          wmask[`CTL_WIDTH-1:0]);
            if (avs_address == `OFS_IRQ_MASK)
                irq_mask_r <= (irq_mask_r & ~wmask[`IRQ_WIDTH-1:0]) |
                              (avs_writedata[`IRQ_WIDTH-1:0] &
                               wmask[`IRQ_WIDTH-1:0]);
        end
    end

    // sticky events; a set in the clearing cycle wins
    assign irq_evt = {commit & ~filter_pass, commit & frm_overrun, commit};
    assign irq_clr = (avs_write & ack_r & avs_address == `OFS_IRQ_STATUS) ?
                     (avs_writedata[`IRQ_WIDTH-1:0] &
                      wmask[`IRQ_WIDTH-1:0]) : {`IRQ_WIDTH{1'b0}};

    always @* begin
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
    end

    always @(posedge mclk) begin
        if (rst) begin
            irq_stat_r <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);
endmodule // mac_rx_frame_status_word

// *** sim/rx_src_model.sv ***
`timescale 1ns/10ps
// receive datapath stand-in, one completion pulse per frame
module rx_src_model (
    // clock
    input  wire        mclk,
    // frame attributes
    output reg         frm_done,
    output reg         frm_overrun,
    output reg  [47:0] frm_dest_addr,
    output reg  [4:0]  frm_flags,
    output reg  [15:0] frm_len,
    output reg  [1:0]  frm_vlan_tags
);
    initial begin
        frm_done = 1'b0;
        frm_overrun = 1'b0;
        frm_dest_addr = 48'h0;
        frm_flags = 5'h0;
        frm_len = 16'h0;
        frm_vlan_tags = 2'h0;
    end

    // flags: addr fail, ctrl, op ok, error, spare
    task send(input o, input [4:0] fl, input [47:0] a,
              input [15:0] l, input [1:0] t);
        begin
            @(posedge mclk);
            frm_done <= 1'b1;
            frm_overrun <= o;
            frm_dest_addr <= a;
            frm_flags <= fl;
            frm_len <= l;
            frm_vlan_tags <= t;
            @(posedge mclk);
            // stale lines except done and the tags inverted so nothing reuses them by accident
            frm_done <= 1'b0;
            frm_overrun <= ~o;
            frm_dest_addr <= ~a;
            frm_flags <= ~fl;
            frm_len <= ~l;
        end
    endtask
endmodule // rx_src_model

// *** sim/rx_stat_chk.sv ***
`timescale 1ns/10ps
// port-level watcher for the status block
module rx_stat_chk #(
    parameter ADDR_W = 48
) (
    // clock, reset, bus
    input wire              mclk,
    input wire              rst,
    input wire [3:0]        avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    // frame side
    input wire              frm_done,
    input wire              frm_overrun,
    input wire [ADDR_W-1:0] frm_dest_addr,
    input wire              frm_addr_fail,
    input wire              promisc_mode,
    input wire              buf_done,
    input wire              frame_stored
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    reg  [3:0] fl_r;
    wire       st_rd;
    // keep the committed frame's flags, the status word is read later
    always @(posedge mclk) begin
        if (rst) fl_r <= 4'h0;
        else if (frame_stored) fl_r <= {frm_overrun, frm_addr_fail,
            &frm_dest_addr, frm_dest_addr[0]};
    end
    assign st_rd = avs_read & ~avs_waitrequest & buf_done &
                   (avs_address == 4'h0);

    chk_wait_first: assert property ($rose(avs_read | avs_write)
        |-> avs_waitrequest) else $error("no wait state");
    chk_wait_one: assert property ((avs_read | avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
    chk_store_done: assert property (frame_stored |=> buf_done)
        else $error("done flag late");
    chk_done_hold: assert property (buf_done && !avs_write |=>
        buf_done) else $error("done flag lost");
    chk_store_cause: assert property (frame_stored |-> frm_done &&
        !buf_done) else $error("stray commit");
    chk_drop_fail: assert property (frm_done && !frm_overrun &&
        !promisc_mode && frm_addr_fail |-> !frame_stored)
        else $error("failed frame kept");
    chk_ovr_flag: assert property (st_rd |->
        avs_readdata[31] == fl_r[3]) else $error("overrun bit");
    chk_fail_flag: assert property (st_rd |->
        avs_readdata[29] == fl_r[2]) else $error("match fail bit");
    chk_bcast_flag: assert property (st_rd |->
        avs_readdata[28] == fl_r[1]) else $error("broadcast bit");
    chk_group_flag: assert property (st_rd |->
        avs_readdata[27] == fl_r[0]) else $error("group bit");
    cover property (frame_stored);
    cover property (st_rd && avs_readdata[30]);
    cover property (frm_done && !frame_stored);
endmodule // rx_stat_chk

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    reg         mclk, rst, rd, wr, promisc;
    reg  [3:0]  adr;
    reg  [31:0] wdat, r, word;
    wire [31:0] rdat;
    wire [1:0]  resp, vt;
    wire [47:0] da;
    wire [15:0] ln;
    wire [4:0]  fl;
    wire        wreq, done, ov, stored, bd, irq;
    reg  [34:0] expq[$];
    integer     miscompares = 0, num_checks = 0, cyc = 0, i;
    reg  [5:0]  ctl;
    reg  [2:0]  msk, ist;
    reg  [3:0]  be;
    reg  [47:0] a;
    reg  [15:0] l, lim;
    reg  [1:0]  t;
    reg         f, bc, c_is, c_ok, e, o, un, pass, keep;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    mac_rx_frame_status_word dut (.mclk(mclk), .rst(rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .avs_response(resp), .frm_done(done),
        .frm_overrun(ov), .frm_dest_addr(da), .frm_addr_fail(fl[4]),
        .frm_is_ctrl(fl[3]), .frm_ctrl_op_ok(fl[2]), .frm_error(fl[1]),
        .frm_len(ln), .frm_vlan_tags(vt), .promisc_mode(promisc),
        .buf_done(bd), .frame_stored(stored), .irq(irq));
    rx_src_model src (.mclk(mclk), .frm_done(done), .frm_overrun(ov),
        .frm_dest_addr(da), .frm_flags(fl), .frm_len(ln),
        .frm_vlan_tags(vt));

    task end_sim;
        begin
            $display("checks %0d miscompares %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // one request, held until waitrequest is seen low at an edge
    task bus(input w, input [3:0] ad, input [31:0] d);
        begin
            rd <= !w;
            wr <= w;
            adr <= ad;
            wdat <= d;
            @(posedge mclk);
            while (wreq) @(posedge mclk);
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task rdx(input [3:0] ad, input [34:0] x);
        begin
            expq.push_back(x);
            bus(1'b0, ad, 32'h0);
        end
    endtask

    task cmp(input [34:0] got, input [34:0] x);
        begin
            num_checks = num_checks + 1;
            if (got !== x) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, x);
            end
        end
    endtask

    // monitor: irq, response and data at each accepted read
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            miscompares = miscompares + 1;
            end_sim;
        end else if (!rst && rd && !wreq) begin
            if (expq.size() == 0) cmp(35'h0, 35'h7ffffffff);
            else cmp({irq, resp, rdat}, expq.pop_front());
        end
    end

    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0;
        promisc = 1'b0;
        be = 4'hf;
        r = $urandom(32'h8bc3);
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdx(4'h0, 35'h0);
        bus(1'b1, 4'h0, 32'hffffffff);
        rdx(4'h0, 35'h0);
        rdx(4'h2, {1'b0, 2'b11, 32'h0});
        // write with no byte lanes must leave the mask alone
        be <= 4'h0;
        bus(1'b1, 4'hc, 32'h7);
        be <= 4'hf;
        rdx(4'hc, 35'h0);
        // receive still disabled: a good frame leaves no status
        src.send(1'b0, 5'h0, 48'h0, 16'h40, 2'h0);
        rdx(4'h0, 35'h0);
        $display("register test done");
        for (i = 0; i < 40; i = i + 1) begin
            r = $urandom;
            ctl = {1'b1, r[4:0]};
            msk = r[8:6];
            promisc <= r[9];
            {f, e, c_is, c_ok} = r[13:10];
            o = r[14] & r[15];
            t = r[17:16];
            a = {$urandom, r[31:16]};
            a[0] = r[20];
            if (r[19:18] == 2'b00) a = {48{1'b1}};
            bc = &a;
            lim = (t == 2'h0) ? 16'h5dc :
                  (t == 2'h1) ? 16'h5ee : 16'h602;
            l = (r[22:21] == 2'b00) ? 16'h40 :
                lim + {14'h0, r[24:23]} - 16'h2;
            un = ctl[4] & c_is & (!c_ok | l != 16'h40);
            pass = !((!f & (!bc | ctl[0])) |
                     (bc & !ctl[1]) |
                     (!c_is | ctl[2]) |
                     (!(e | l > lim) | ctl[3]) |
                     !un);
            keep = o | (r[9] ? !(bc & ctl[1]) :
                        !(f | (bc & ctl[1])));
            word = keep ? {o, pass, f, bc, a[0], 27'h0}
                        : 32'h0;
            ist = keep ? {!pass, o, 1'b1} : 3'h0;
            bus(1'b1, 4'h4, 32'h0);
            bus(1'b1, 4'h8, 32'h7);
            bus(1'b1, 4'hc, {29'h0, msk});
            bus(1'b1, 4'h4, {26'h0, ctl});
            src.send(o, {f, c_is, c_ok, e, 1'b0}, a, l, t);
            rdx(4'h0, {|(ist & msk), 2'b00, word});
            rdx(4'h8, {|(ist & msk), 2'b00, 29'h0, ist});
            if (keep) begin
                bus(1'b1, 4'h0, ~word);
                src.send(!o, {!f, c_is, c_ok, e, 1'b0}, ~a, l, t);
                rdx(4'h0, {|(ist & msk), 2'b00, word});
            end
        end
        $display("frame test done");
        end_sim;
    end
endmodule // tb_top

bind mac_rx_frame_status_word rx_stat_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frm_done(frm_done),
    .frm_overrun(frm_overrun), .frm_dest_addr(frm_dest_addr),
    .frm_addr_fail(frm_addr_fail), .promisc_mode(promisc_mode),
    .buf_done(buf_done), .frame_stored(frame_stored));
